/* verilog/obs_pkg.sv */
/*
  Shared constants and carrier types for the test signal observation mux,
  plus the small input synchroniser that the mux top instantiates.
  Assumes one system clock; tap signals arrive from other clock domains.
*/
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// package
package obs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ANALOG  = 8'h00;
  localparam logic [7:0] OFS_DIGITAL = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  // field positions and widths
  localparam int unsigned SRC_LSB   = 0;
  localparam int unsigned SRC_W     = 3;
  localparam int unsigned ROUTE_BIT = 3;
  localparam int unsigned ANA_W     = 5;
  localparam int unsigned DIG_W     = 8;
  localparam int unsigned TAP_LSB   = 8;
  // reset values
  localparam logic [4:0] ANA_RST = 5'h00;
  localparam logic [7:0] DIG_RST = 8'h00;
  localparam logic [2:0] SRC_RST = 3'h0;
  // observation source codes
  localparam logic [2:0] SRC_LOW  = 3'h0;
  localparam logic [2:0] SRC_HIGH = 3'h1;
  localparam logic [2:0] SRC_ENV  = 3'h2;
  localparam logic [2:0] SRC_NRZ  = 3'h3;
  localparam logic [2:0] SRC_MSUB = 3'h4;
  localparam logic [2:0] SRC_MAN  = 3'h5;
  // digital test codes
  localparam logic [7:0] DIG_NONE  = 8'h00;
  localparam logic [7:0] DIG_DATA  = 8'hf4;
  localparam logic [7:0] DIG_VALID = 8'he4;
  localparam logic [7:0] DIG_COLL  = 8'hd4;
  localparam logic [7:0] DIG_SCLK  = 8'hc4;
  localparam logic [7:0] DIG_RD    = 8'hb5;
  localparam logic [7:0] DIG_WR    = 8'ha5;
  localparam logic [7:0] DIG_CORE  = 8'h96;
  // last defined analog node code
  localparam logic [4:0] ANA_LAST = 5'h0c;
  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
  // ahb encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // internal taps that can be observed
  typedef struct packed {
    logic tx_envelope;
    logic tx_nrz;
    logic rx_manch_sub;
    logic rx_manch;
    logic rx_bit_data;
    logic rx_bit_valid;
    logic rx_bit_coll;
    logic serial_clock;
    logic rd_strobe;
    logic wr_strobe;
    logic core_clock;
  } taps_t;
  localparam int unsigned TAP_W = $bits(taps_t);

  // software selection state
  typedef struct packed {
    logic [4:0] analog_node_code;
    logic [7:0] digital_test_code;
    logic       digital_route_bit;
    logic [2:0] observe_source_code;
  } sel_t;
endpackage

// ==========================================================================
// synchroniser
module tap_sync #(
  parameter int unsigned WIDTH = 11
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  if (WIDTH < 1) begin : g_bad_width
    $error("tap_sync needs at least one bit");
  end

  // two flops per bit; the first is read only by the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_r;
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_r <= 1'b0;
        q[i]   <= 1'b0;
      end else begin
        meta_r <= d[i];
        q[i]   <= meta_r;
      end
    end
  end
endmodule

`default_nettype wire

/* verilog/observe_mux.sv */
/*
  Test signal observation mux with an AHB-Lite register slave.
  Routes serial coding taps, receiver and interface taps or a fixed
  level to the digital observation pin, and an analog node code to the
  auxiliary analog switch. Assumes taps come from foreign domains and
  that the analog switch itself lives outside this block.
*/
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module observe_mux #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              SYS_RST,
  // ahb-lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output var  logic [31:0]       HRDATA,
  output var  logic              HREADYOUT,
  output var  logic              HRESP,
  // internal taps, asynchronous to this clock
  input  wire obs_pkg::taps_t    TAP_IN,
  // observation outputs
  output var  logic              DIGITAL_OBSERVE_PIN,
  output var  logic [4:0]        AUX_NODE_SEL,
  output var  logic              AUX_NODE_EN
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
    $error("observe_mux address width must be 4 to 32");
  end

  // ========================================================================
  // tap synchronisers
  obs_pkg::taps_t taps_s;
  logic [obs_pkg::TAP_W-1:0] taps_q;

  tap_sync #(
    .WIDTH (obs_pkg::TAP_W)
  ) u_sync (
    .clk (CLK_SYS),
    .rst (SYS_RST),
    .d   (TAP_IN),
    .q   (taps_q)
  );
  assign taps_s = obs_pkg::taps_t'(taps_q);

  // ========================================================================
  // ahb address phase capture
  logic              ph_valid_r, ph_valid_nxt;
  logic              ph_write_r, ph_write_nxt;
  logic [ADDR_W-1:0] ph_addr_r,  ph_addr_nxt;
  logic              take_addr;

  // slave never stalls, so every selected NONSEQ is taken at once
  assign take_addr = HSEL && HTRANS[1] && HREADY;

  always_comb begin
    ph_valid_nxt = take_addr;
    ph_write_nxt = take_addr && HWRITE && (HSIZE == obs_pkg::HSIZE_WORD);
    ph_addr_nxt  = take_addr ? HADDR[ADDR_W-1:0] : ph_addr_r;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r  <= '0;
    end else begin
      ph_valid_r <= ph_valid_nxt;
      ph_write_r <= ph_write_nxt;
      ph_addr_r  <= ph_addr_nxt;
    end
  end

  // ========================================================================
  // selection registers
  obs_pkg::sel_t sel_r, sel_nxt;

  // write lands in the data phase; unmapped offsets are dropped
  always_comb begin
    sel_nxt = sel_r;
    if (ph_valid_r && ph_write_r) begin
      unique case (8'(ph_addr_r))
        obs_pkg::OFS_ANALOG:
          sel_nxt.analog_node_code = HWDATA[obs_pkg::ANA_W-1:0];
        obs_pkg::OFS_DIGITAL:
          sel_nxt.digital_test_code = HWDATA[obs_pkg::DIG_W-1:0];
        obs_pkg::OFS_CONTROL: begin
          sel_nxt.observe_source_code =
            HWDATA[obs_pkg::SRC_LSB +: obs_pkg::SRC_W];
          sel_nxt.digital_route_bit = HWDATA[obs_pkg::ROUTE_BIT];
        end
        default: ;
      endcase
    end
  end

  // test code resets to no test signal
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sel_r.analog_node_code    <= obs_pkg::ANA_RST;
      sel_r.digital_test_code   <= obs_pkg::DIG_RST;
      sel_r.digital_route_bit   <= 1'b0;
      sel_r.observe_source_code <= obs_pkg::SRC_RST;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // ========================================================================
  // observation outputs
  logic       pin_r, pin_nxt;
  logic [4:0] aux_sel_r, aux_sel_nxt;
  logic       aux_en_r, aux_en_nxt;
  logic       src_level;

  // serial switch, used with the route bit clear or test code 00h
  always_comb begin
    unique case (sel_r.observe_source_code)
      obs_pkg::SRC_LOW:  src_level = 1'b0;
      obs_pkg::SRC_HIGH: src_level = 1'b1;
      obs_pkg::SRC_ENV:  src_level = taps_s.tx_envelope;
      obs_pkg::SRC_NRZ:  src_level = taps_s.tx_nrz;
      obs_pkg::SRC_MSUB: src_level = taps_s.rx_manch_sub;
      obs_pkg::SRC_MAN:  src_level = taps_s.rx_manch;
      default:           src_level = 1'b0;
    endcase
  end

  // registered pin: a code change never shows a combinational glitch
  always_comb begin
    pin_nxt = src_level;
    if (sel_r.digital_route_bit) begin
      unique case (sel_r.digital_test_code)
        obs_pkg::DIG_NONE:  pin_nxt = src_level;
        obs_pkg::DIG_DATA:  pin_nxt = taps_s.rx_bit_data;
        obs_pkg::DIG_VALID: pin_nxt = taps_s.rx_bit_valid;
        obs_pkg::DIG_COLL:  pin_nxt = taps_s.rx_bit_coll;
        obs_pkg::DIG_SCLK:  pin_nxt = taps_s.serial_clock;
        obs_pkg::DIG_RD:    pin_nxt = taps_s.rd_strobe;
        obs_pkg::DIG_WR:    pin_nxt = taps_s.wr_strobe;
        obs_pkg::DIG_CORE:  pin_nxt = taps_s.core_clock;
        default:            pin_nxt = 1'b0;
      endcase
    end
  end

  // reserved analog codes open the switch rather than pick a node
  always_comb begin
    aux_sel_nxt = sel_r.analog_node_code;
    aux_en_nxt  = sel_r.analog_node_code <= obs_pkg::ANA_LAST;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pin_r     <= 1'b0;
      aux_sel_r <= obs_pkg::ANA_RST;
      aux_en_r  <= 1'b0;
    end else begin
      pin_r     <= pin_nxt;
      aux_sel_r <= aux_sel_nxt;
      aux_en_r  <= aux_en_nxt;
    end
  end

  assign DIGITAL_OBSERVE_PIN = pin_r;
  assign AUX_NODE_SEL        = aux_sel_r;
  assign AUX_NODE_EN         = aux_en_r;

  // ========================================================================
  // read data and response
  logic [31:0] rdata_r, rdata_nxt;
  logic        ready_r;
  logic        resp_r;

  // read uses next selection so a read right after a write sees it
  always_comb begin
    rdata_nxt = rdata_r;
    if (take_addr && !HWRITE) begin
      rdata_nxt = '0;
      unique case (8'(HADDR[ADDR_W-1:0]))
        obs_pkg::OFS_ANALOG:
          rdata_nxt[obs_pkg::ANA_W-1:0] = sel_nxt.analog_node_code;
        obs_pkg::OFS_DIGITAL:
          rdata_nxt[obs_pkg::DIG_W-1:0] = sel_nxt.digital_test_code;
        obs_pkg::OFS_CONTROL: begin
          rdata_nxt[obs_pkg::SRC_LSB +: obs_pkg::SRC_W] =
            sel_nxt.observe_source_code;
          rdata_nxt[obs_pkg::ROUTE_BIT] = sel_nxt.digital_route_bit;
        end
        obs_pkg::OFS_STATUS: begin
          rdata_nxt[0] = pin_r;
          rdata_nxt[1] = aux_en_r;
          rdata_nxt[obs_pkg::TAP_LSB +: obs_pkg::TAP_W] = taps_s;
        end
        default: ;
      endcase
    end
  end

  // zero wait state, always OKAY
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdata_r <= '0;
      ready_r <= 1'b1;
      resp_r  <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= 1'b1;
      resp_r  <= 1'b0;
    end
  end

  assign HRDATA    = rdata_r;
  assign HREADYOUT = ready_r;
  assign HRESP     = resp_r;

  // ========================================================================
  // assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  logic src_mode;
  assign src_mode = !sel_r.digital_route_bit ||
                    (sel_r.digital_test_code == obs_pkg::DIG_NONE);

  a_fixed_levels: assert property (
    src_mode && sel_r.observe_source_code inside {3'h0, 3'h6, 3'h7}
    |=> !DIGITAL_OBSERVE_PIN)
    else $error("fixed low source not low");
  a_nrz_source: assert property (
    src_mode && sel_r.observe_source_code == obs_pkg::SRC_NRZ
    |=> DIGITAL_OBSERVE_PIN == $past(taps_s.tx_nrz))
    else $error("nrz source mismatch");
  a_env_source: assert property (
    src_mode && sel_r.observe_source_code == obs_pkg::SRC_ENV
    |=> DIGITAL_OBSERVE_PIN == $past(taps_s.tx_envelope))
    else $error("envelope source mismatch");
  a_rx_manch: assert property (
    src_mode && sel_r.observe_source_code inside {3'h4, 3'h5}
    |=> DIGITAL_OBSERVE_PIN == ($past(sel_r.observe_source_code[0]) ?
        $past(taps_s.rx_manch) : $past(taps_s.rx_manch_sub)))
    else $error("manchester source mismatch");
  a_high_override: assert property (
    sel_r.digital_route_bit &&
    sel_r.digital_test_code == obs_pkg::DIG_CORE &&
    sel_r.observe_source_code == obs_pkg::SRC_HIGH
    |=> DIGITAL_OBSERVE_PIN == $past(taps_s.core_clock))
    else $error("route bit does not override source");
  a_data_code: assert property (
    sel_r.digital_route_bit && sel_r.digital_test_code == obs_pkg::DIG_DATA
    |=> DIGITAL_OBSERVE_PIN == $past(taps_s.rx_bit_data))
    else $error("received data code mismatch");
  a_valid_code: assert property (
    sel_r.digital_route_bit && sel_r.digital_test_code == obs_pkg::DIG_VALID
    |=> DIGITAL_OBSERVE_PIN == $past(taps_s.rx_bit_valid))
    else $error("valid code mismatch");
  a_coll_code: assert property (
    sel_r.digital_route_bit && sel_r.digital_test_code == obs_pkg::DIG_COLL
    |=> DIGITAL_OBSERVE_PIN == $past(taps_s.rx_bit_coll))
    else $error("collision code mismatch");
  a_sclk_code: assert property (
    sel_r.digital_route_bit && sel_r.digital_test_code == obs_pkg::DIG_SCLK
    |=> DIGITAL_OBSERVE_PIN == $past(taps_s.serial_clock))
    else $error("serial clock code mismatch");
  a_strobe_codes: assert property (
    sel_r.digital_route_bit && sel_r.digital_test_code inside {8'hb5, 8'ha5}
    |=> DIGITAL_OBSERVE_PIN == ($past(sel_r.digital_test_code[4]) ?
        $past(taps_s.rd_strobe) : $past(taps_s.wr_strobe)))
    else $error("strobe code mismatch");
  a_none_code: assert property (
    sel_r.digital_route_bit && sel_r.digital_test_code == obs_pkg::DIG_NONE &&
    sel_r.observe_source_code == obs_pkg::SRC_HIGH |=> DIGITAL_OBSERVE_PIN)
    else $error("code 00h does not follow source");
  a_analog_node: assert property (
    ##1 AUX_NODE_SEL == $past(sel_r.analog_node_code))
    else $error("analog node code not routed");
  a_analog_resv: assert property (
    sel_r.analog_node_code > obs_pkg::ANA_LAST |=> !AUX_NODE_EN)
    else $error("reserved analog code enabled switch");
  a_write_latency: assert property (
    ph_valid_r && ph_write_r && 8'(ph_addr_r) == obs_pkg::OFS_CONTROL &&
    HWDATA[obs_pkg::ROUTE_BIT] == 1'b0 && HWDATA[2:0] == obs_pkg::SRC_HIGH
    |=> ##1 DIGITAL_OBSERVE_PIN)
    else $error("selection not applied one cycle after write");
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("slave stalled or answered error");

  c_nrz_seen: cover property (
    src_mode && sel_r.observe_source_code == obs_pkg::SRC_NRZ ##1
    DIGITAL_OBSERVE_PIN);
  c_data_seen: cover property (
    sel_r.digital_route_bit && sel_r.digital_test_code == obs_pkg::DIG_DATA
    ##1 DIGITAL_OBSERVE_PIN);
  c_resv_analog: cover property (
    sel_r.analog_node_code > obs_pkg::ANA_LAST);
  c_read_after_write: cover property (
    ph_valid_r && ph_write_r && take_addr && !HWRITE);

endmodule

`default_nettype wire

/* sim/tap_model.sv */
/*
  Behavioural source of the internal taps seen by the observation mux.
  Assumes the bench picks one tap index (taps_t bit, core clock is 0)
  and the level that tap should carry.
*/
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// tap source
module tap_model (
  // selection from the bench
  input  wire logic [3:0]     pick,
  input  wire logic           lvl,
  // taps towards the mux
  output var  obs_pkg::taps_t taps
);
  logic [10:0] one_hot;

  // every other tap sits at the opposite level, so a wrong route shows
  assign one_hot = 11'h001 << pick;
  assign taps    = obs_pkg::taps_t'(lvl ? one_hot : ~one_hot);
endmodule

`default_nettype wire

/* sim/observe_mux_tb_top.sv */
/*
  Self-checking bench for the observation mux: registers over AHB-Lite,
  pin routing for every source and each listed test code, analog node codes.
  Assumes obs_pkg and observe_mux are compiled first; zero wait states
  are not assumed, the master waits for hready.
*/
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// bench top
module observe_mux_tb_top;
  logic           CLK_SYS;
  logic           SYS_RST;
  logic           HSEL;
  logic [31:0]    HADDR;
  logic [1:0]     HTRANS;
  logic           HWRITE;
  logic [2:0]     HSIZE;
  logic [31:0]    HWDATA;
  logic [31:0]    HRDATA;
  logic           HREADYOUT;
  logic           HRESP;
  logic           DIGITAL_OBSERVE_PIN;
  logic [4:0]     AUX_NODE_SEL;
  logic           AUX_NODE_EN;
  obs_pkg::taps_t taps;
  logic [3:0]     pick;
  logic           lvl;
  logic [31:0]    rd;
  int             err_count;
  int             num_checks;

  observe_mux observe_mux_i (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .TAP_IN(taps), .DIGITAL_OBSERVE_PIN(DIGITAL_OBSERVE_PIN),
    .AUX_NODE_SEL(AUX_NODE_SEL), .AUX_NODE_EN(AUX_NODE_EN)
  );

  tap_model tap_model_i (.pick(pick), .lvl(lvl), .taps(taps));

  // 125 MHz system clock
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  // hang guard, far above the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    err_count++;
    print_verdict();
  end

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one write: address phase, then data phase, each held until hready
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [2:0] sz = obs_pkg::HSIZE_WORD);
    HADDR  <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= 1'b1;
    HSIZE  <= sz;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
  endtask

  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    HADDR  <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= 1'b0;
    HSIZE  <= obs_pkg::HSIZE_WORD;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    d = HRDATA;
  endtask

  // program selection and taps, let sync and output stages settle
  task automatic probe(input logic [7:0] tc, input logic [3:0] ctl,
                       input logic [3:0] p, input logic l, input logic e);
    ahb_wr(obs_pkg::OFS_DIGITAL, {24'h0, tc});
    ahb_wr(obs_pkg::OFS_CONTROL, {28'h0, ctl});
    pick <= p;
    lvl  <= l;
    repeat (5) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    check(32'(DIGITAL_OBSERVE_PIN), 32'(e));
    @(posedge CLK_SYS);
  endtask

  // ========================================================================
  // scenarios
  task automatic t_reset();
    ahb_rd(obs_pkg::OFS_ANALOG, rd);
    check(rd, 32'h0);
    ahb_rd(obs_pkg::OFS_DIGITAL, rd);
    check(rd, 32'h0);
    ahb_rd(obs_pkg::OFS_CONTROL, rd);
    check(rd, 32'h0);
    // taps idle at pick 0 low: core clock low, the rest high
    ahb_rd(obs_pkg::OFS_STATUS, rd);
    check(rd, 32'h0007fe02);
    check(32'({DIGITAL_OBSERVE_PIN, AUX_NODE_EN, HRESP}), 32'h2);
  endtask

  // source codes 0..7 with the route bit clear, both tap levels
  task automatic t_source();
    logic [3:0] s;
    for (int i = 0; i < 16; i++) begin
      s = 4'(i >> 1);
      if (s >= 4'h2 && s <= 4'h5) begin
        probe(8'h00, s, 4'd12 - s, 1'(i), 1'(i));
      end else begin
        probe(8'h00, s, 4'h0, 1'(i), s == 4'h1);
      end
    end
  endtask

  // listed test codes with the source set high, which must be ignored, and code 00h, which follows the source
  task automatic t_digital();
    // only listed codes are ever written, both tap levels each
    for (int l = 0; l < 2; l++) begin
      probe(obs_pkg::DIG_DATA,  4'h9, 4'h6, 1'(l), 1'(l));
      probe(obs_pkg::DIG_VALID, 4'h9, 4'h5, 1'(l), 1'(l));
      probe(obs_pkg::DIG_COLL,  4'h9, 4'h4, 1'(l), 1'(l));
      probe(obs_pkg::DIG_SCLK,  4'h9, 4'h3, 1'(l), 1'(l));
      probe(obs_pkg::DIG_RD,    4'h9, 4'h2, 1'(l), 1'(l));
      probe(obs_pkg::DIG_WR,    4'h9, 4'h1, 1'(l), 1'(l));
      probe(obs_pkg::DIG_CORE,  4'h9, 4'h0, 1'(l), 1'(l));
    end
    probe(8'h00, 4'h9, 4'h0, 1'b0, 1'b1);
    probe(8'h00, 4'h8, 4'h0, 1'b1, 1'b0);
  endtask

  // new selection shows one cycle after the write, not before
  task automatic t_timing();
    ahb_wr(obs_pkg::OFS_CONTROL, 32'h1);
    @(negedge CLK_SYS);
    check(32'(DIGITAL_OBSERVE_PIN), 32'h0);
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    check(32'(DIGITAL_OBSERVE_PIN), 32'h1);
    @(posedge CLK_SYS);
    // halfword write and unmapped read are ignored, still okay
    ahb_wr(obs_pkg::OFS_CONTROL, 32'h0, 3'h1);
    ahb_rd(obs_pkg::OFS_CONTROL, rd);
    check(rd, 32'h1);
    ahb_rd(8'h10, rd);
    check({rd[30:0], HRESP}, 32'h0);
    ahb_wr(obs_pkg::OFS_CONTROL, 32'h0);
  endtask

  // every analog node code, reserved ones drop the enable
  task automatic t_analog();
    for (int c = 0; c < 32; c++) begin
      ahb_wr(obs_pkg::OFS_ANALOG, 32'(c));
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      check(32'(AUX_NODE_SEL), 32'(c));
      check(32'(AUX_NODE_EN), 32'(c <= 12));
      @(posedge CLK_SYS);
      ahb_rd(obs_pkg::OFS_ANALOG, rd);
      check(rd, 32'(c));
    end
    ahb_wr(obs_pkg::OFS_ANALOG, 32'h0);
  endtask

  // ========================================================================
  // main sequence
  initial begin
    SYS_RST    = 1'b1;
    HSEL       = 1'b1;
    HADDR      = 32'h0;
    HTRANS     = 2'h0;
    HWRITE     = 1'b0;
    HSIZE      = obs_pkg::HSIZE_WORD;
    HWDATA     = 32'h0;
    pick       = 4'h0;
    lvl        = 1'b0;
    err_count  = 0;
    num_checks = 0;
    repeat (20) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    t_reset();
    t_source();
    t_digital();
    t_timing();
    t_analog();
    print_verdict();
  end
endmodule

`default_nettype wire
